// [shared/eac_pkg.sv]
// Package: register map, field layout, timing and state types of the EEPROM access control
package eac_pkg;
    // Register indices; the bus byte address is the low six index bits times four
    localparam logic [7:0] IDX_CTRL = 8'h3f;
    localparam logic [7:0] IDX_DATA = 8'h40;
    localparam logic [7:0] IDX_PTRL = 8'h41;
    localparam logic [7:0] IDX_PTRH = 8'h42;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h43;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h44;
    localparam logic [7:0] IDX_SYS = 8'h45;
    // Control register fields
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_WSTRB_BIT = 1;
    localparam int CTRL_ARM_BIT = 2;
    localparam int CTRL_RIE_BIT = 3;
    localparam int CTRL_PAS_LSB = 4;
    // System register fields: global irq enable, self program active
    localparam int SYS_GIE_BIT = 0;
    localparam int SYS_SPM_BIT = 1;
    // Irq status fields
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam int IRQ_W = 2;
    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] PAS_RST = 2'h0;
    // Program actions
    localparam logic [1:0] PAS_ERASE_WRITE = 2'h0;
    localparam logic [1:0] PAS_ERASE = 2'h1;
    localparam logic [1:0] PAS_WRITE = 2'h2;
    // Timing
    localparam int ARM_WINDOW_CYC = 4;
    localparam int WSTALL_CYC = 2;
    localparam int RSTALL_CYC = 4;
    localparam int RC_WRITE_CYC = 26368;
    localparam int RC_SHORT_CYC = 14063;
    typedef enum {EAC_IDLE, EAC_PROG} eac_state_t;
endpackage : eac_pkg

// [shared/eac_arr_if.sv]
// Interface: connection between the control logic and the byte array
`timescale 1ns/1ps
interface eac_arr_if #(parameter int AW = 9);
    logic rd;
    logic wr;
    logic er;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output rd, output wr, output er, output addr, output wdata, input rdata);
    modport mem (input rd, input wr, input er, input addr, input wdata, output rdata);
endinterface : eac_arr_if

// [src/eac_array.sv]
// Byte-wide nonvolatile array model with combinational read
`timescale 1ns/1ps
module eac_array #(
    parameter int AW = 9
) (
    input wire logic i_core_clk,
    eac_arr_if.mem arr
);
    logic [7:0] mem [0:(1<<AW)-1];
    assign arr.rdata = mem[arr.addr];
    always_ff @(posedge i_core_clk) begin
        if (arr.er && arr.wr) begin
            mem[arr.addr] <= arr.wdata;
        end else if (arr.er) begin
            mem[arr.addr] <= 8'hff;
        end else if (arr.wr) begin
            mem[arr.addr] <= mem[arr.addr] & arr.wdata;
        end
    end
endmodule : eac_array

// [src/eac_timer.sv]
// Write duration timer counting calibrated oscillator ticks
`timescale 1ns/1ps
module eac_timer #(
    parameter int LONG_CYC = eac_pkg::RC_WRITE_CYC,
    parameter int SHORT_CYC = eac_pkg::RC_SHORT_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_rc_tick,
    input wire logic i_start,
    input wire logic i_short,
    output logic o_done
);
    logic [15:0] count;
    logic running;
    always_ff @(posedge i_core_clk) begin
        o_done <= 1'b0;
        if (i_start) begin
            running <= 1'b1;
            count <= i_short ? 16'(SHORT_CYC - 1) : 16'(LONG_CYC - 1);
        end else if (running && i_rc_tick) begin
            if (count == 16'h0000) begin
                running <= 1'b0;
                o_done <= 1'b1;
            end else begin
                count <= count - 16'h0001;
            end
        end
        if (!i_nrst && !running) begin
            count <= 16'h0000;
        end
    end
endmodule : eac_timer

// [src/eac_ctrl.sv]
// EEPROM access control: Wishbone registers, arming, strobes, stalls, ready irq
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// [RULE1] Armed strobe within four cycles starts write
// [RULE2] Strobe without arm does nothing
// [RULE3] Arm bit self-clears after four cycles
// [RULE4] Software polls, loads, arms, then strobes
// [RULE5] No programming while flash self-programs
// [RULE6] Software disables interrupts during write sequence
// [RULE7] Strobe stays set until write completes
// [RULE8] Write start stalls core two cycles
// [RULE9] Read strobe loads data register immediately
// [RULE10] Read stalls core four cycles
// [RULE11] During write refuse reads, pointer changes
// [RULE12] Software polls strobe before reading
// [RULE13] Erase-write timed by 26368 oscillator ticks, erase or write alone by 14063
// [RULE14] Action select chooses operation, locked while busy
// [RULE15] Ready irq while idle, enabled, global
// [RULE16] Byte pointer linear, load before use
// [RULE17] Ignore data and strobe writes while busy
module eac_ctrl #(
    parameter int AW = 9,
    parameter int LONG_CYC = eac_pkg::RC_WRITE_CYC,
    parameter int SHORT_CYC = eac_pkg::RC_SHORT_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_rc_tick,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_core_stall,
    output logic o_ready_irq,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
        hit = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'h0);
    endfunction : hit
    logic req;
    logic wr_lane;
    logic wr_ctrl;
    logic wr_data;
    logic wr_ptrl;
    logic wr_ptrh;
    logic wr_stat;
    logic wr_mask;
    logic wr_sys;
    logic [7:0] wb;
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr_lane = req && i_wb_we && i_wb_sel[0];
    assign wb = i_wb_dat[7:0];
    assign wr_ctrl = wr_lane && hit(i_wb_adr, eac_pkg::IDX_CTRL);
    assign wr_data = wr_lane && hit(i_wb_adr, eac_pkg::IDX_DATA);
    assign wr_ptrl = wr_lane && hit(i_wb_adr, eac_pkg::IDX_PTRL);
    assign wr_ptrh = wr_lane && hit(i_wb_adr, eac_pkg::IDX_PTRH);
    assign wr_stat = wr_lane && hit(i_wb_adr, eac_pkg::IDX_IRQ_STAT);
    assign wr_mask = wr_lane && hit(i_wb_adr, eac_pkg::IDX_IRQ_MASK);
    assign wr_sys = wr_lane && hit(i_wb_adr, eac_pkg::IDX_SYS);
    ////////////////////////////////////////////////////////////////////////////
    // State
    eac_arr_if #(.AW(AW)) arr ();
    eac_pkg::eac_state_t state;
    logic master_write_arm;
    logic [2:0] arm_count;
    logic write_strobe;
    logic ready_irq_enable;
    logic [1:0] program_action_select;
    logic [7:0] nv_data_register;
    logic [AW-1:0] nv_byte_pointer;
    logic global_irq_enable;
    logic self_program_active;
    logic [2:0] stall_count;
    logic [eac_pkg::IRQ_W-1:0] irq_stat;
    logic [eac_pkg::IRQ_W-1:0] irq_mask;
    logic start_write;
    logic read_go;
    logic read_refused;
    logic timer_done;
    logic busy;
    logic [7:0] ctrl_view;
    logic [7:0] ptrh_view;
    logic [15:0] ptr_wide;
    logic [7:0] prog_data;
    assign busy = (state == eac_pkg::EAC_PROG);
    assign start_write = wr_ctrl && wb[eac_pkg::CTRL_WSTRB_BIT] && master_write_arm
        && !busy && !self_program_active; // [RULE1] [RULE2] [RULE5] [RULE17]
    assign read_go = wr_ctrl && wb[eac_pkg::CTRL_READ_BIT] && !busy; // [RULE11]
    assign read_refused = wr_ctrl && wb[eac_pkg::CTRL_READ_BIT] && busy;
    ////////////////////////////////////////////////////////////////////////////
    // Arm bit with four-cycle window
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            master_write_arm <= 1'b0;
            arm_count <= 3'h0;
        end else if (wr_ctrl && wb[eac_pkg::CTRL_ARM_BIT] && !wb[eac_pkg::CTRL_WSTRB_BIT]) begin
            master_write_arm <= 1'b1;
            arm_count <= 3'(eac_pkg::ARM_WINDOW_CYC);
        end else if (start_write) begin
            master_write_arm <= 1'b0;
            arm_count <= 3'h0;
        end else if (arm_count != 3'h0) begin
            arm_count <= arm_count - 3'h1;
            master_write_arm <= (arm_count != 3'h1); // [RULE3]
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write sequencing and strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            if (!busy) begin
                state <= eac_pkg::EAC_IDLE;
                write_strobe <= 1'b0;
            end
        end else begin
            case (state)
                eac_pkg::EAC_IDLE: begin
                    if (start_write) begin
                        state <= eac_pkg::EAC_PROG;
                        write_strobe <= 1'b1; // [RULE7]
                    end
                end
                eac_pkg::EAC_PROG: begin
                    if (timer_done) begin
                        state <= eac_pkg::EAC_IDLE;
                        write_strobe <= 1'b0; // [RULE7]
                    end
                end
                default: begin
                    state <= eac_pkg::EAC_IDLE;
                    write_strobe <= 1'b0;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Action select and ready enable
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ready_irq_enable <= 1'b0;
            if (!busy) begin
                program_action_select <= eac_pkg::PAS_RST;
            end
        end else if (wr_ctrl) begin
            ready_irq_enable <= wb[eac_pkg::CTRL_RIE_BIT];
            if (!write_strobe) begin
                program_action_select <= wb[eac_pkg::CTRL_PAS_LSB +: 2]; // [RULE14]
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pointer and data registers
    assign ptr_wide = {8'h00, wb} << 8;
    always_ff @(posedge i_core_clk) begin
        if (wr_ptrl && !busy) begin
            nv_byte_pointer[7:0] <= wb; // [RULE11] [RULE16]
        end
        if (wr_ptrh && !busy && AW > 8) begin
            nv_byte_pointer <= AW'({ptr_wide[15:8], nv_byte_pointer[7:0]}); // [RULE11] [RULE16]
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            nv_data_register <= eac_pkg::DATA_RST;
        end else if (read_go) begin
            nv_data_register <= arr.rdata; // [RULE9]
        end else if (wr_data && !busy) begin
            nv_data_register <= wb; // [RULE17]
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // System inputs register
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            global_irq_enable <= 1'b0;
            self_program_active <= 1'b0;
        end else if (wr_sys) begin
            global_irq_enable <= wb[eac_pkg::SYS_GIE_BIT];
            self_program_active <= wb[eac_pkg::SYS_SPM_BIT];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Core stall
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            stall_count <= 3'h0;
        end else if (start_write) begin
            stall_count <= 3'(eac_pkg::WSTALL_CYC); // [RULE8]
        end else if (read_go) begin
            stall_count <= 3'(eac_pkg::RSTALL_CYC); // [RULE10]
        end else if (stall_count != 3'h0) begin
            stall_count <= stall_count - 3'h1;
        end
    end
    assign o_core_stall = (stall_count != 3'h0);
    ////////////////////////////////////////////////////////////////////////////
    // Array drive and timer
    assign arr.addr = nv_byte_pointer;
    // Data snapshot so a reset during programming cannot corrupt the byte
    always_ff @(posedge i_core_clk) begin
        if (start_write) begin
            prog_data <= nv_data_register; // [RULE17]
        end
    end
    assign arr.wdata = prog_data;
    assign arr.rd = read_go;
    assign arr.wr = timer_done && (program_action_select != eac_pkg::PAS_ERASE);
    assign arr.er = timer_done && (program_action_select != eac_pkg::PAS_WRITE);
    eac_timer #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_timer (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_rc_tick(i_rc_tick),
        .i_start(start_write),
        .i_short(program_action_select != eac_pkg::PAS_ERASE_WRITE),
        .o_done(timer_done) // [RULE13]
    );
    eac_array #(.AW(AW)) u_array (
        .i_core_clk(i_core_clk),
        .arr(arr)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Interrupts
    assign o_ready_irq = ready_irq_enable && global_irq_enable && !write_strobe
        && !self_program_active; // [RULE15]
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_mask) begin
                irq_mask <= wb[eac_pkg::IRQ_W-1:0];
            end
            irq_stat <= (irq_stat & ~(wr_stat ? wb[eac_pkg::IRQ_W-1:0] : '0))
                | {read_refused, timer_done};
        end
    end
    assign o_irq = |(irq_stat & irq_mask);
    ////////////////////////////////////////////////////////////////////////////
    // Read back
    assign ctrl_view = {2'h0, program_action_select, ready_irq_enable, master_write_arm,
        write_strobe, 1'b0};
    assign ptrh_view = 8'(nv_byte_pointer >> 8);
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= 32'h00000000;
            if (req && !i_wb_we) begin
                if (hit(i_wb_adr, eac_pkg::IDX_CTRL)) o_wb_dat[7:0] <= ctrl_view;
                if (hit(i_wb_adr, eac_pkg::IDX_DATA)) o_wb_dat[7:0] <= nv_data_register;
                if (hit(i_wb_adr, eac_pkg::IDX_PTRL)) o_wb_dat[7:0] <= nv_byte_pointer[7:0];
                if (hit(i_wb_adr, eac_pkg::IDX_PTRH)) o_wb_dat[7:0] <= ptrh_view;
                if (hit(i_wb_adr, eac_pkg::IDX_IRQ_STAT)) o_wb_dat[1:0] <= irq_stat;
                if (hit(i_wb_adr, eac_pkg::IDX_IRQ_MASK)) o_wb_dat[1:0] <= irq_mask;
                if (hit(i_wb_adr, eac_pkg::IDX_SYS)) begin
                    o_wb_dat[1:0] <= {self_program_active, global_irq_enable};
                end
            end
        end
    end
endmodule : eac_ctrl

// [tb/eac_ctrl_sva.sv]
// Checker: bus, stall and reset properties of the access control
`timescale 1ns/1ps
module eac_ctrl_sva (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_wb_adr,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_core_stall,
    input wire logic o_irq
);
    wire logic req = i_wb_cyc & i_wb_stb;
    wire logic cw = req & i_wb_we & (i_wb_adr == {eac_pkg::IDX_CTRL[5:0], 2'b00});
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////
    AST_ACK_TAKE: assert property (req && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(req))
        else $error("ack without request");
    AST_DAT_UPPER: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_STALL_LEN: assert property ($rose(o_core_stall) |->
        (o_core_stall[*2] ##1 !o_core_stall) or (o_core_stall[*4] ##1 !o_core_stall))
        else $error("stall length not two or four");
    AST_STALL_CAUSE: assert property ($rose(o_core_stall) |->
        $past(cw) || $past(cw, 2))
        else $error("stall without control write");
    AST_READ_NO_STALL: assert property (req && !i_wb_we && !o_core_stall |=> !o_core_stall)
        else $error("bus read started a stall");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        $rose(i_nrst) |-> !o_wb_ack && !o_core_stall && !o_irq)
        else $error("outputs not cleared by reset");
endmodule : eac_ctrl_sva

bind eac_ctrl eac_ctrl_sva i_sva (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_wb_adr(i_wb_adr),
    .i_wb_we(i_wb_we),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .o_core_stall(o_core_stall),
    .o_irq(o_irq)
);

// [tb/tb.sv]
// Testbench: registers, write arming, program actions, stalls, irqs
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [7:0] d;
        logic [7:0] e;
    } eac_row_t;
    localparam int LONG = 20;
    localparam int SHORT = 10;
    localparam logic [7:0] I_CT = eac_pkg::IDX_CTRL;
    localparam logic [7:0] I_DA = eac_pkg::IDX_DATA;
    localparam logic [7:0] I_PL = eac_pkg::IDX_PTRL;
    localparam logic [7:0] I_PH = eac_pkg::IDX_PTRH;
    localparam logic [7:0] I_ST = eac_pkg::IDX_IRQ_STAT;
    localparam logic [7:0] I_MK = eac_pkg::IDX_IRQ_MASK;
    localparam logic [7:0] I_SY = eac_pkg::IDX_SYS;
    localparam eac_row_t ROWS [10] = '{
        '{I_CT, 1'b0, 8'h00, 8'h00}, '{I_DA, 1'b0, 8'h00, 8'h00},
        '{I_ST, 1'b0, 8'h00, 8'h00}, '{I_MK, 1'b0, 8'h00, 8'h00},
        '{I_SY, 1'b0, 8'h00, 8'h00}, '{8'h60, 1'b1, 8'hff, 8'h00},
        '{I_MK, 1'b1, 8'h03, 8'h03}, '{I_DA, 1'b1, 8'h5a, 8'h5a},
        '{I_ST, 1'b1, 8'h03, 8'h00}, '{I_SY, 1'b1, 8'h01, 8'h01}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic stall;
    logic rdy;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int stalls = 0;
    int s0;
    int t0;
    logic [7:0] dv [3] = '{8'ha5, 8'h00, 8'h3c};
    logic [7:0] ev [3] = '{8'ha5, 8'hff, 8'h3c};
    logic [1:0] pv [3] = '{eac_pkg::PAS_ERASE_WRITE, eac_pkg::PAS_ERASE, eac_pkg::PAS_WRITE};
    int nv [3] = '{LONG, SHORT, SHORT};
    eac_ctrl #(.AW(9), .LONG_CYC(LONG), .SHORT_CYC(SHORT)) i_dut (
        .i_core_clk(clk),
        .i_nrst(nrst),
        .i_rc_tick(tick),
        .i_wb_adr(adr),
        .i_wb_dat(dat),
        .i_wb_sel(sel),
        .i_wb_we(we),
        .i_wb_cyc(cyc),
        .i_wb_stb(stb),
        .o_wb_dat(rdat),
        .o_wb_ack(ack),
        .o_core_stall(stall),
        .o_ready_irq(rdy),
        .o_irq(irq)
    );
    ////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;
    always @(posedge clk) begin
        tick <= ~tick;
        cycles <= cycles + 1;
        if (stall === 1'b1) begin
            stalls <= stalls + 1;
        end
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i[5:0], 2'b00};
        dat <= {24'h0, d};
        sel <= 4'h1;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(i, 1'b1, d, q);
    endtask : wr
    task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(i, 1'b0, 8'h00, q);
        chk(q, e);
    endtask : rdchk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].w) begin
                wr(ROWS[i].a, ROWS[i].d);
            end
            rdchk(ROWS[i].a, ROWS[i].e);
        end
        $display("test registers done");
        s0 = stalls;
        wr(I_CT, 8'h0a);
        rdchk(I_CT, 8'h08);
        wr(I_CT, 8'h0c);
        rdchk(I_CT, 8'h0c);
        rdchk(I_CT, 8'h08);
        wr(I_CT, 8'h0a);
        rdchk(I_CT, 8'h08);
        wr(I_SY, 8'h03);
        chk({7'h0, rdy}, 8'h00);
        wr(I_CT, 8'h0c);
        wr(I_CT, 8'h0a);
        rdchk(I_CT, 8'h08);
        wr(I_SY, 8'h01);
        chk(8'(stalls - s0), 8'h00);
        $display("test refused writes done");
        for (int k = 0; k < 3; k++) begin
            wr(I_PL, 8'hff);
            wr(I_PH, 8'h01);
            wr(I_DA, dv[k]);
            wr(I_CT, {2'b00, pv[k], 4'b1100});
            s0 = stalls;
            wr(I_CT, {2'b00, pv[k], 4'b1010});
            t0 = cycles;
            rdchk(I_CT, {2'b00, pv[k], 4'b1010});
            chk(8'(stalls - s0), 8'h02);
            if (k == 0) begin
                chk({7'h0, rdy}, 8'h00);
                wr(I_PL, 8'h00);
                wr(I_DA, 8'h11);
                rdchk(I_DA, dv[0]);
                wr(I_CT, 8'h39);
                rdchk(I_CT, 8'h0a);
                chk({7'h0, irq}, 8'h01);
            end
            while (rdy !== 1'b1 && cycles - t0 < 200) @(posedge clk);
            chk({7'h0, (cycles - t0 > 2 * nv[k] - 5) && (cycles - t0 < 2 * nv[k] + 5)},
                8'h01);
            rdchk(I_CT, {2'b00, pv[k], 4'b1000});
            rdchk(I_ST, (k == 0) ? 8'h03 : 8'h01);
            if (k == 1) begin
                wr(I_MK, 8'h00);
            end
            chk({7'h0, irq}, (k == 1) ? 8'h00 : 8'h01);
            wr(I_MK, 8'h03);
            wr(I_ST, 8'h03);
            rdchk(I_ST, 8'h00);
            chk({7'h0, irq}, 8'h00);
            wr(I_DA, 8'h00);
            s0 = stalls;
            wr(I_CT, 8'h09);
            rdchk(I_DA, ev[k]);
            repeat (4) @(posedge clk);
            chk(8'(stalls - s0), 8'h04);
            $display("test action %0d done", k);
        end
        wr(I_CT, 8'h0c);
        wr(I_CT, 8'h0a);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdchk(I_CT, 8'h02);
        rdchk(I_DA, 8'h00);
        $display("test reset during write done");
        print_verdict();
    end
endmodule : tb
